// >>> pdmac_pkg.sv
package pdmac_pkg;
    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam logic [8:0]  OFF_RX_PTR   = 9'h100; // Receive pointer
    localparam logic [8:0]  OFF_RX_CNT   = 9'h104; // Receive counter
    localparam logic [8:0]  OFF_TX_PTR   = 9'h108; // Transmit pointer
    localparam logic [8:0]  OFF_TX_CNT   = 9'h10C; // Transmit counter
    localparam logic [8:0]  OFF_RX_NPTR  = 9'h110; // Receive next pointer
    localparam logic [8:0]  OFF_RX_NCNT  = 9'h114; // Receive next counter
    localparam logic [8:0]  OFF_TX_NPTR  = 9'h118; // Transmit next pointer
    localparam logic [8:0]  OFF_TX_NCNT  = 9'h11C; // Transmit next counter
    localparam logic [8:0]  OFF_CMD      = 9'h120; // Transfer command
    localparam logic [8:0]  OFF_STAT     = 9'h124; // Transfer state
    localparam logic [8:0]  CH_STRIDE    = 9'h008; // Rx to tx offset step
    localparam int          CH_BIT_STEP  = 8;      // Rx to tx bit step
    localparam int          EN_BIT       = 0;      // Enable bit in a lane
    localparam int          DIS_BIT      = 1;      // Disable bit in a lane
    localparam int          CNT_W        = 16;     // Counter field width
    localparam logic [31:0] RST_PTR      = 32'h0;  // Pointer reset value
    localparam logic [15:0] RST_CNT      = 16'h0;  // Counter reset value
    localparam logic [31:0] STEP_BYTE    = 32'h1;  // Byte increment
    localparam logic [31:0] STEP_HALF    = 32'h2;  // Half-word increment
    localparam logic [31:0] STEP_WORD    = 32'h4;  // Word increment
    localparam logic [1:0]  SIZE_BYTE    = 2'h0;   // Byte transfer code
    localparam logic [1:0]  SIZE_HALF    = 2'h1;   // Half-word code
    localparam int          FIFO_DEPTH   = 8;      // Receive buffer depth
    localparam int          CH_RX        = 0;      // Receive channel index
    localparam int          CH_TX        = 1;      // Transmit channel index

    // Register access from the host peripheral
    typedef struct packed {
        logic        sel;   // Access strobe
        logic        wr;    // Write when set, read otherwise
        logic [8:0]  addr;  // Byte offset in peripheral space
        logic [31:0] wdata; // Write data
    } pdmac_reg_req_t;

    // Request toward system memory
    typedef struct packed {
        logic        req;   // Held until acknowledged
        logic        write; // Write to memory when set
        logic [31:0] addr;  // Memory address
        logic [31:0] wdata; // Write data
        logic [1:0]  size;  // Transfer size code
    } pdmac_mem_req_t;
endpackage

// >>> pdmac_fifo.sv
`timescale 1ns/10ps
module pdmac_fifo #(
    parameter int W = 32, // Word width
    parameter int D = 8   // Depth, power of two
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);
    // ****************************************
    // Storage and pointers
    // ****************************************
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];       // Word storage
    logic [AW-1:0] wrPtr_ff;     // Write index
    logic [AW-1:0] rdPtr_ff;     // Read index
    logic [AW:0]   count_ff;     // Words held
    logic [W-1:0]  outData_ff;   // Registered head word
    logic          push;
    logic          pop;
    logic [AW-1:0] nxt_rdPtr;

    // Refuse depths the pointer wrap cannot serve
    initial
    begin
        if (D < 2 || (1 << AW) != D)
            $error("pdmac_fifo: depth must be a power of two");
    end

    assign inReady  = (count_ff != D[AW:0]);
    assign outValid = (count_ff != '0);
    assign push     = ce && inValid && inReady;
    assign pop      = ce && outValid && outReady;
    assign nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
    assign outData  = outData_ff;

    // Write into storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_ff] <= inData;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            wrPtr_ff <= push ? wrPtr_ff + 1'b1 : wrPtr_ff;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Head word, forwarded when written into the slot being read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            outData_ff <= '0;
        else if (ce)
            outData_ff <= (push && wrPtr_ff == nxt_rdPtr) ? inData
                                                          : mem[nxt_rdPtr];
    end
endmodule // pdmac_fifo

// >>> pdmac_channel_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Ten channel registers from offset 0x100
// - Receive counter low 16 bits, upper reserved
// - Transmit pointer 32-bit, read/write, resets zero
// - Transmit stops while its counter is zero
// - Receive next pointer names following buffer
// - Receive next counter 16-bit, resets zero
// - Transmit next pointer and counter, consecutive
// - Command register write-only, acts, not stored
// - Status register reports both enables
// - Pointer steps 1/2/4, counter decrements
// - At zero, load next pair, clear next counter
// - End and all-done flags; counter write clears
// - Enable/disable command bits; disable prevails
module pdmac_channel_regs
    import pdmac_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic                      ce,
    input  wire pdmac_pkg::pdmac_reg_req_t regReq,
    output logic                    [31:0] regRdata,
    input  wire logic               [1:0]  xferSize,
    input  wire logic                      rxValid,
    output logic                           rxReady,
    input  wire logic               [31:0] rxData,
    input  wire logic                      txReq,
    output logic                           txValid,
    output logic                    [31:0] txData,
    output pdmac_pkg::pdmac_mem_req_t      memReq,
    input  wire logic                      memAck,
    input  wire logic               [31:0] memRdata,
    output logic                           rxEndFlag,
    output logic                           rxAllFullFlag,
    output logic                           txEndFlag,
    output logic                           txAllEmptyFlag
);
    import pdmac_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [1:0] {IDLE, RXW, TXR} pdmac_state_t;

    pdmac_state_t  state_ff;          // Memory port owner
    logic [31:0]   ptr_ff   [2];      // Current pointers
    logic [15:0]   cnt_ff   [2];      // Current counters
    logic [31:0]   nptr_ff  [2];      // Next pointers
    logic [15:0]   ncnt_ff  [2];      // Next counters
    logic [1:0]    en_ff;             // Request enables
    logic [1:0]    endF_ff;           // Current buffer ended
    logic [1:0]    bufF_ff;           // Both buffers ended
    logic [31:0]   regRdata_ff;       // Read data
    logic          txValid_ff;        // Fetched word strobe
    logic [31:0]   txData_ff;         // Fetched word
    logic [1:0]    done;              // Transfer finished this cycle
    logic [1:0]    wrCnt;             // Counter written this cycle
    logic [1:0]    wrNcnt;            // Next counter written
    logic [1:0]    wrPtr;             // Pointer written
    logic [1:0]    reload;            // Chaining this cycle
    logic [31:0]   step;              // Pointer increment
    logic          wrAcc;             // Register write strobe
    logic          rdAcc;             // Register read strobe
    logic          fifoValid;         // Receive word waiting
    logic          fifoPop;           // Receive word leaves
    logic [31:0]   fifoData;          // Receive head word
    logic [31:0]   nxt_regRdata;
    logic          startRx;
    logic          startTx;

    assign wrAcc = ce && regReq.sel && regReq.wr;
    assign rdAcc = ce && regReq.sel && !regReq.wr;

    // Increment follows the transfer width
    // pointer step size
    assign step = (xferSize == SIZE_BYTE) ? STEP_BYTE :
                  (xferSize == SIZE_HALF) ? STEP_HALF : STEP_WORD;

    // ****************************************
    // Receive buffering
    // ****************************************
    // Back-pressure reaches the peripheral through rxReady
    pdmac_fifo #(
        .W (32),
        .D (FIFO_DEPTH)
    ) u_rxFifo (
        .clk      (clk),
        .resetn   (resetn),
        .ce       (ce),
        .inValid  (rxValid),
        .inReady  (rxReady),
        .inData   (rxData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // ****************************************
    // Memory port sequencing
    // ****************************************
    // Receive drains first; a zero counter holds either side off
    // zero count stops
    assign startRx = fifoValid && en_ff[CH_RX] && cnt_ff[CH_RX] != '0;
    assign startTx = txReq && !txValid_ff && en_ff[CH_TX]
                     && cnt_ff[CH_TX] != '0;
    assign done[CH_RX] = ce && state_ff == RXW && memAck;
    assign done[CH_TX] = ce && state_ff == TXR && memAck;
    assign fifoPop     = done[CH_RX];

    // Port owner state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= IDLE;
        else if (ce)
        begin
            case (state_ff)
                IDLE:
                begin
                    if (startRx)
                        state_ff <= RXW;
                    else if (startTx)
                        state_ff <= TXR;
                end
                RXW, TXR:
                begin
                    if (memAck)
                        state_ff <= IDLE;
                end
                default: state_ff <= IDLE;
            endcase
        end
    end

    // Request drawn from the live pointer, so a rewrite redirects it
    always_comb
    begin
        memReq       = '0;
        memReq.req   = (state_ff != IDLE);
        memReq.write = (state_ff == RXW);
        memReq.addr  = (state_ff == TXR) ? ptr_ff[CH_TX] : ptr_ff[CH_RX];
        memReq.wdata = fifoData;
        memReq.size  = xferSize;
    end

    // Fetched word toward the peripheral, one-cycle strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            txValid_ff <= 1'b0;
            txData_ff  <= '0;
        end
        else if (ce)
        begin
            txValid_ff <= done[CH_TX];
            if (done[CH_TX])
                txData_ff <= memRdata;
        end
    end

    assign txValid = txValid_ff;
    assign txData  = txData_ff;

    // ****************************************
    // Per-channel register sets
    // ****************************************
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch
        localparam logic [8:0] BASE = OFF_RX_PTR + 9'(ch) * CH_STRIDE;
        localparam int         LANE = ch * CH_BIT_STEP;

        // Address decode shared by both directions
        // fixed channel offsets
        assign wrPtr[ch]  = wrAcc && regReq.addr == BASE;
        assign wrCnt[ch]  = wrAcc && regReq.addr == BASE + 9'h004;
        assign wrNcnt[ch] = wrAcc
                            && regReq.addr == BASE + (OFF_RX_NCNT - OFF_RX_PTR);
        assign reload[ch] = ce && cnt_ff[ch] == '0 && ncnt_ff[ch] != '0
                            && !wrCnt[ch];

        // Current pointer; software write beats stepping
        // pointer storage
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                ptr_ff[ch] <= RST_PTR;
            else if (wrPtr[ch])
                ptr_ff[ch] <= regReq.wdata;
            else if (done[ch])
                ptr_ff[ch] <= ptr_ff[ch] + step;
            else if (reload[ch])
                ptr_ff[ch] <= nptr_ff[ch];
        end

        // Current counter, low 16 bits only
        // counter storage
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                cnt_ff[ch] <= RST_CNT;
            else if (wrCnt[ch])
                cnt_ff[ch] <= regReq.wdata[CNT_W-1:0];
            else if (done[ch])
                cnt_ff[ch] <= cnt_ff[ch] - 16'h1;
            else if (reload[ch])
                cnt_ff[ch] <= ncnt_ff[ch];
        end

        // Next buffer description
        // next registers
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                nptr_ff[ch] <= RST_PTR;
                ncnt_ff[ch] <= RST_CNT;
            end
            else
            begin
                if (wrAcc && regReq.addr == BASE + (OFF_RX_NPTR - OFF_RX_PTR))
                    nptr_ff[ch] <= regReq.wdata;
                if (wrNcnt[ch])
                    ncnt_ff[ch] <= regReq.wdata[CNT_W-1:0];
                else if (reload[ch])
                    ncnt_ff[ch] <= RST_CNT;
            end
        end

        // Enable from command writes; nothing is stored for readback
        // command decode
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                en_ff[ch] <= 1'b0;
            else if (wrAcc && regReq.addr == OFF_CMD)
            begin
                if (regReq.wdata[LANE + DIS_BIT])
                    en_ff[ch] <= 1'b0;
                else if (regReq.wdata[LANE + EN_BIT])
                    en_ff[ch] <= 1'b1;
            end
        end

        // Sticky end flags; a same-cycle event beats the clear
        // end flags
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                endF_ff[ch] <= 1'b0;
                bufF_ff[ch] <= 1'b0;
            end
            else if (done[ch] && cnt_ff[ch] == 16'h1)
            begin
                endF_ff[ch] <= 1'b1;
                if (ncnt_ff[ch] == '0)
                    bufF_ff[ch] <= 1'b1;
            end
            else if (wrCnt[ch] || wrNcnt[ch])
            begin
                endF_ff[ch] <= 1'b0;
                bufF_ff[ch] <= 1'b0;
            end
        end
    end

    assign rxEndFlag      = endF_ff[CH_RX];
    assign rxAllFullFlag  = bufF_ff[CH_RX];
    assign txEndFlag      = endF_ff[CH_TX];
    assign txAllEmptyFlag = bufF_ff[CH_TX];

    // ****************************************
    // Register readback
    // ****************************************
    // Unmapped offsets and the command register read as zero
    always_comb
    begin
        nxt_regRdata = '0;
        case (regReq.addr)
            OFF_RX_PTR:  nxt_regRdata = ptr_ff[CH_RX];
            OFF_RX_CNT:  nxt_regRdata = {16'h0, cnt_ff[CH_RX]};
            OFF_TX_PTR:  nxt_regRdata = ptr_ff[CH_TX];
            OFF_TX_CNT:  nxt_regRdata = {16'h0, cnt_ff[CH_TX]};
            OFF_RX_NPTR: nxt_regRdata = nptr_ff[CH_RX];
            OFF_RX_NCNT: nxt_regRdata = {16'h0, ncnt_ff[CH_RX]};
            OFF_TX_NPTR: nxt_regRdata = nptr_ff[CH_TX];
            OFF_TX_NCNT: nxt_regRdata = {16'h0, ncnt_ff[CH_TX]};
            OFF_STAT:
            begin
                nxt_regRdata[CH_BIT_STEP * CH_RX + EN_BIT] = en_ff[CH_RX];
                nxt_regRdata[CH_BIT_STEP * CH_TX + EN_BIT] = en_ff[CH_TX];
            end
            default: nxt_regRdata = '0;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            regRdata_ff <= '0;
        else if (rdAcc)
            regRdata_ff <= nxt_regRdata;
    end

    assign regRdata = regRdata_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence sFetchEnd;
        state_ff == TXR && memAck && ce;
    endsequence

    sequence sStrobe;
        txValid && txData == $past(memRdata);
    endsequence

    a_dis_prevails: assert property (
        wrAcc && regReq.addr == OFF_CMD && regReq.wdata[0] && regReq.wdata[1]
        |=> !en_ff[CH_RX])
        else $error("disable did not prevail");

    a_ptr_step: assert property (
        done[CH_RX] && !wrPtr[CH_RX]
        |=> ptr_ff[CH_RX] == $past(ptr_ff[CH_RX]) + $past(step))
        else $error("pointer step wrong");

    a_cnt_dec: assert property (
        done[CH_TX] && !wrCnt[CH_TX]
        |=> cnt_ff[CH_TX] == $past(cnt_ff[CH_TX]) - 16'h1)
        else $error("counter did not decrement");

    a_chain_load: assert property (
        reload[CH_RX] && !wrPtr[CH_RX] && !wrNcnt[CH_RX]
        |=> cnt_ff[CH_RX] == $past(ncnt_ff[CH_RX]) && ncnt_ff[CH_RX] == '0
            && ptr_ff[CH_RX] == $past(nptr_ff[CH_RX]))
        else $error("chaining load wrong");

    a_end_set: assert property (
        done[CH_TX] && cnt_ff[CH_TX] == 16'h1 ##1 1'b1
        |-> txEndFlag && (txAllEmptyFlag == ($past(ncnt_ff[CH_TX]) == '0)))
        else $error("end flags not raised");

    a_end_clear: assert property (
        wrCnt[CH_RX] && !done[CH_RX] |=> !rxEndFlag && !rxAllFullFlag)
        else $error("end flag not cleared");

    a_tx_stops: assert property (
        state_ff == IDLE && cnt_ff[CH_TX] == '0 |=> state_ff != TXR)
        else $error("transmit ran at zero count");

    a_fetch_strobe: assert property (
        sFetchEnd |=> sStrobe ##1 !txValid || !ce)
        else $error("fetch strobe wrong");

    a_stat_read: assert property (
        rdAcc && regReq.addr == OFF_STAT
        |=> regRdata == {23'h0, $past(en_ff[CH_TX]), 7'h0,
                         $past(en_ff[CH_RX])})
        else $error("status readback wrong");

    a_cmd_read: assert property (
        rdAcc && regReq.addr == OFF_CMD |=> regRdata == '0)
        else $error("command register readable");
endmodule // pdmac_channel_regs

// >>> pdmac_mem_model.sv
`timescale 1ns/10ps
module pdmac_mem_model
    import pdmac_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire pdmac_pkg::pdmac_mem_req_t memReq,
    input  wire logic                      slow,
    output logic                           memAck,
    output logic                    [31:0] memRdata,
    output logic                    [31:0] lastAddr,
    output logic                    [31:0] lastData,
    output int                             ackCnt
);
    logic [1:0] waitCnt; // Wait states spent on the open request

    // Answer at once or after three waits; read data churns when idle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            memAck   <= 1'b0;
            memRdata <= 32'h0;
            lastAddr <= 32'h0;
            lastData <= 32'h0;
            ackCnt   <= 0;
            waitCnt  <= 2'h0;
        end
        else
        begin
            memAck   <= 1'b0;
            memRdata <= ~memRdata;
            // Never answer the same request twice
            if (memReq.req && !memAck)
            begin
                if (!slow || waitCnt == 2'h3)
                begin
                    memAck   <= 1'b1;
                    memRdata <= memReq.addr ^ 32'hA5A5A5A5;
                    lastAddr <= memReq.addr;
                    lastData <= memReq.wdata;
                    ackCnt   <= ackCnt + 1;
                    waitCnt  <= 2'h0;
                end
                else
                begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
        end
    end
endmodule // pdmac_mem_model

// >>> pdmac_channel_regs_test.sv
`timescale 1ns/10ps
module pdmac_channel_regs_test;
    import pdmac_pkg::*;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic           clk = 1'b0;
    logic           resetn = 1'b0;
    pdmac_reg_req_t regReq = '0;
    logic [1:0]     xferSize = 2'h0;
    logic           rxValid = 1'b0, txReq = 1'b0, slow = 1'b0;
    logic [31:0]    rxData = 32'h0, regRdata, txData, memRdata;
    logic [31:0]    lastAddr, lastData;
    logic           rxReady, txValid, memAck;
    logic           rxEnd, rxAll, txEnd, txAll;
    pdmac_mem_req_t memReq;
    int             ackCnt, n_errors = 0, comparisons = 0, cycles = 0;

    // Free running 50 MHz clock
    always #10 clk = ~clk;

    pdmac_channel_regs dut (.clk(clk), .resetn(resetn), .ce(1'b1),
        .regReq(regReq), .regRdata(regRdata), .xferSize(xferSize),
        .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
        .txReq(txReq), .txValid(txValid), .txData(txData),
        .memReq(memReq), .memAck(memAck), .memRdata(memRdata),
        .rxEndFlag(rxEnd), .rxAllFullFlag(rxAll), .txEndFlag(txEnd),
        .txAllEmptyFlag(txAll));

    pdmac_mem_model mem (.clk(clk), .resetn(resetn), .memReq(memReq),
        .slow(slow), .memAck(memAck), .memRdata(memRdata),
        .lastAddr(lastAddr), .lastData(lastData), .ackCnt(ackCnt));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One register write, strobe held across one taking edge
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(negedge clk);
        regReq = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        regReq = '0;
    endtask

    // Read data is registered, so look one edge after the take
    task automatic rdchk(input logic [8:0] a, input logic [31:0] e);
        @(negedge clk);
        regReq = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(negedge clk);
        regReq = '0;
        chk(regRdata, e);
    endtask

    // Offer one word, held until the buffer has room
    task automatic push(input logic [31:0] d);
        int i;
        @(negedge clk);
        rxValid = 1'b1;
        rxData = d;
        for (i = 0; i < 50 && rxReady !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        rxValid = 1'b0;
    endtask

    // The model counts at its answer edge; the design takes it one edge
    // later and chains one edge after that, so let both settle first
    task automatic waitAck(input int t);
        int i;
        for (i = 0; i < 200 && ackCnt < t; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        chk(ackCnt, t);
    endtask

    // Counter first, so a stale next count cannot chain in
    task automatic setup(input logic [8:0] b, input logic [31:0] p,
                         input logic [31:0] c, input logic [31:0] np,
                         input logic [31:0] nc);
        wr(b + 9'h4, c);
        wr(b, p);
        wr(b + 9'h10, np);
        wr(b + 9'h14, nc);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        int i;
        for (i = 0; i < 10; i++)
            rdchk(9'h100 + 9'(4 * i), 32'h0);
    endtask

    // Counters keep only their low half; unmapped place stays empty
    task automatic t_regs();
        int i;
        for (i = 0; i < 8; i++)
            wr(9'h100 + 9'(4 * i), 32'hDEAD0100 + 32'(4 * i));
        wr(9'h128, 32'hFFFFFFFF);
        for (i = 0; i < 8; i++)
            rdchk(9'h100 + 9'(4 * i), (i % 2 == 1) ? 32'h100 + 32'(4 * i)
                  : 32'hDEAD0100 + 32'(4 * i));
        rdchk(9'h128, 32'h0);
    endtask

    task automatic t_cmd();
        wr(OFF_CMD, 32'h303);
        rdchk(OFF_STAT, 32'h0);
        wr(OFF_CMD, 32'h101);
        rdchk(OFF_STAT, 32'h101);
        rdchk(OFF_CMD, 32'h0);
        wr(OFF_CMD, 32'h301);
        rdchk(OFF_STAT, 32'h1);
        wr(OFF_CMD, 32'h3);
        rdchk(OFF_STAT, 32'h0);
    endtask

    // Half-word steps, then a chain into the next buffer
    task automatic t_rx();
        int b;
        b = ackCnt;
        xferSize = 2'h1;
        setup(OFF_RX_PTR, 32'h1000, 32'h2, 32'h2000, 32'h1);
        wr(OFF_CMD, 32'h1);
        push(32'h11);
        waitAck(b + 1);
        chk(lastAddr, 32'h1000);
        chk(lastData, 32'h11);
        push(32'h22);
        waitAck(b + 2);
        chk(lastAddr, 32'h1002);
        rdchk(OFF_RX_NCNT, 32'h0);
        rdchk(OFF_RX_PTR, 32'h2000);
        chk(rxEnd, 32'h1);
        chk(rxAll, 32'h0);
        push(32'h33);
        waitAck(b + 3);
        chk(lastAddr, 32'h2000);
        rdchk(OFF_RX_CNT, 32'h0);
        chk(rxAll, 32'h1);
        wr(OFF_RX_CNT, 32'h0);
        @(negedge clk);
        chk(rxEnd, 32'h0);
    endtask

    // One word fetch, then nothing more while the count is zero
    task automatic t_tx();
        int i;
        int n;
        xferSize = 2'h2;
        setup(OFF_TX_PTR, 32'h3000, 32'h1, 32'h0, 32'h0);
        wr(OFF_CMD, 32'h100);
        txReq = 1'b1;
        for (i = 0; i < 50 && txValid !== 1'b1; i++) @(negedge clk);
        txReq = 1'b0;
        chk(txValid, 32'h1);
        chk(txData, 32'h3000 ^ 32'hA5A5A5A5);
        rdchk(OFF_TX_PTR, 32'h3004);
        chk(txEnd, 32'h1);
        chk(txAll, 32'h1);
        n = 0;
        txReq = 1'b1;
        repeat (20)
        begin
            @(negedge clk);
            if (txValid === 1'b1)
                n++;
        end
        txReq = 1'b0;
        chk(n, 0);
    endtask

    // Fill while disabled, then drain against a slow memory
    task automatic t_fifo();
        int i;
        int b;
        wr(OFF_CMD, 32'h2);
        xferSize = 2'h0;
        setup(OFF_RX_PTR, 32'h4000, 32'h9, 32'h0, 32'h0);
        for (i = 0; i < FIFO_DEPTH; i++)
            push(32'hC0 + 32'(i));
        @(negedge clk);
        chk(rxReady, 32'h0);
        slow = 1'b1;
        b = ackCnt;
        wr(OFF_CMD, 32'h1);
        waitAck(b + 8);
        chk(lastData, 32'hC7);
        rdchk(OFF_RX_PTR, 32'h4008);
        rdchk(OFF_RX_CNT, 32'h1);
        chk(rxReady, 32'h1);
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_regs();
        t_cmd();
        t_rx();
        t_tx();
        t_fifo();
        end_sim();
    end
endmodule // pdmac_channel_regs_test
